/* File: rtl/cgp_pkg.sv */
// Constants, register map and state encodings for the clock gear and prescaler control block.
// Assumes a 32-bit AHB-Lite register bus and one system clock of 100 MHz.
package cgp_pkg;

  localparam int unsigned CLK_SYS_MHZ = 100;

  // Register offsets within the block, byte addresses of aligned words.
  localparam logic [7:0] OFS_SYS_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] OFS_OSCILLATOR_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STANDBY_CONTROL = 8'h08;
  localparam logic [7:0] OFS_PLL_SELECT = 8'h0c;
  localparam logic [7:0] OFS_SYSTEM_CLOCK_SELECT = 8'h10;
  localparam int unsigned ADDR_DEC_W = 8;

  // Field positions of the system clock control register.
  localparam int unsigned CLKOUT_SEL_LSB = 16;
  localparam int unsigned CLKOUT_SEL_MSB = 17;
  localparam int unsigned PERIPH_SRC_BIT = 12;
  localparam int unsigned PRESC_LSB = 8;
  localparam int unsigned PRESC_MSB = 10;
  localparam int unsigned GEAR_LSB = 0;
  localparam int unsigned GEAR_MSB = 2;

  localparam logic [31:0] SYS_CLOCK_CONTROL_RESET = 32'h0001_0000;
  localparam logic [31:0] SYS_CLOCK_CONTROL_WMASK = 32'h0003_1707;

  // Clock output select codes.
  typedef enum logic [1:0] {
    CGP_OUT_LOW_SPEED = 2'h0,
    CGP_OUT_SYS_HALF  = 2'h1,
    CGP_OUT_SYS_FULL  = 2'h2,
    CGP_OUT_PRESC_TAP = 2'h3
  } cgp_clkout_sel_t;

  // Gear codes; all others are reserved and run undivided.
  localparam logic [2:0] GEAR_DIV1 = 3'h0;
  localparam logic [2:0] GEAR_DIV2 = 3'h4;
  localparam logic [2:0] GEAR_DIV4 = 3'h5;
  localparam logic [2:0] GEAR_DIV8 = 3'h6;

  // Largest legal prescaler code (divide by 32); codes above are reserved.
  localparam logic [2:0] PRESC_MAX_CODE = 3'h5;

  // Divider ratios as powers of two.
  localparam logic [2:0] LOG2_DIV1 = 3'h0;
  localparam logic [2:0] LOG2_DIV2 = 3'h1;
  localparam logic [2:0] LOG2_DIV4 = 3'h2;
  localparam logic [2:0] LOG2_DIV8 = 3'h3;
  localparam int unsigned DIV_CNT_W = 5;

  // AHB-Lite encodings used by the slave.
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : cgp_pkg

/* File: rtl/cgp_div.sv */
// Power-of-two tick divider: one output pulse for every 2**log2 source ticks.
// Assumes source ticks are single-cycle pulses on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cgp_div
  import cgp_pkg::*;
#(
  parameter int unsigned CNT_W = DIV_CNT_W
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       en_i,
  input  wire logic [2:0] log2_i,
  output logic            tick_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } cgp_div_state_t;

  cgp_div_state_t state_ff;
  cgp_div_state_t nxt_state;
  logic [CNT_W-1:0] limit;

  // A ratio change mid-count wraps at once rather than running a long stale cycle.
  always_comb begin
    nxt_state = state_ff;
    limit = CNT_W'((1 << log2_i) - 1);
    nxt_state.tick = 1'b0;
    if (en_i) begin
      if (state_ff.cnt >= limit) begin
        nxt_state.cnt = '0;
        nxt_state.tick = 1'b1;
      end else begin
        nxt_state.cnt = state_ff.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tick_o = state_ff.tick;

endmodule // cgp_div
`default_nettype wire

/* File: rtl/cgp_top.sv */
// Clock gear, peripheral source, prescaler and clock-out control with its register bank.
// Assumes clk_sys_i is the high-speed clock, an AHB-Lite master with this as its only slave,
// and an asynchronous low-speed clock level arriving on a pin.
`timescale 1ns/10ps
`default_nettype none
module cgp_top
  import cgp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic [31:0]      hrdata_o,
  output logic             hresp_o,
  input  wire logic        low_speed_clock_i,
  output logic             gear_tick_o,
  output logic             periph_tick_o,
  output logic             presc_tick_o,
  output logic             clock_output_pin_o
);

  typedef struct packed {
    logic [31:0]           sys_ctrl;
    logic                  wr_pend;
    logic [ADDR_DEC_W-1:0] wr_addr;
    logic [31:0]           rdata;
    logic                  ready;
    logic                  resp;
    logic                  ls_meta;
    logic                  ls_sync;
    logic                  periph_tick;
    logic                  half_tgl;
    logic                  pin;
  } cgp_state_t;

  cgp_state_t state_ff;
  cgp_state_t nxt_state;

  logic                  gear_tick;
  logic                  presc_tick;
  logic [2:0]            gear_log2;
  logic [2:0]            presc_log2;
  logic                  periph_src;
  logic [2:0]            gear_code;
  logic [2:0]            presc_code;
  cgp_clkout_sel_t       out_sel;
  logic                  addr_phase;
  logic [ADDR_DEC_W-1:0] addr_ofs;
  logic                  sys_full_rate;
  logic                  presc_full_rate;

  assign gear_code  = state_ff.sys_ctrl[GEAR_MSB:GEAR_LSB];
  assign presc_code = state_ff.sys_ctrl[PRESC_MSB:PRESC_LSB];
  assign periph_src = state_ff.sys_ctrl[PERIPH_SRC_BIT];
  assign out_sel    = cgp_clkout_sel_t'(state_ff.sys_ctrl[CLKOUT_SEL_MSB:CLKOUT_SEL_LSB]);

  // Reserved gear codes fall back to the undivided clock so the core never stalls.
  always_comb begin
    unique case (gear_code)
      GEAR_DIV2: gear_log2 = LOG2_DIV2;
      GEAR_DIV4: gear_log2 = LOG2_DIV4;
      GEAR_DIV8: gear_log2 = LOG2_DIV8;
      default:   gear_log2 = LOG2_DIV1;
    endcase
  end

  // Reserved prescaler codes are treated as undivided for the same reason.
  always_comb begin
    if (presc_code > PRESC_MAX_CODE) begin
      presc_log2 = LOG2_DIV1;
    end else begin
      presc_log2 = presc_code;
    end
  end

  // The geared clock is the system clock; it ticks once per 2**gear_log2 cycles.
  cgp_div #(
    .CNT_W (DIV_CNT_W)
  ) u_gear_div (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .en_i      (1'b1),
    .log2_i    (gear_log2),
    .tick_o    (gear_tick)
  );

  // The prescaler counts peripheral clock ticks; its output is the first timer tap.
  cgp_div #(
    .CNT_W (DIV_CNT_W)
  ) u_presc_div (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .en_i      (state_ff.periph_tick),
    .log2_i    (presc_log2),
    .tick_o    (presc_tick)
  );

  // A flip-flop cannot show a waveform at the full clock rate, so a source that
  // ticks every cycle is shown as a toggle at half rate instead of a stuck level.
  assign sys_full_rate = (gear_log2 == LOG2_DIV1);
  assign presc_full_rate = (presc_log2 == LOG2_DIV1) && (periph_src || sys_full_rate);

  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign addr_ofs   = haddr_i[ADDR_DEC_W-1:0];

  always_comb begin
    nxt_state = state_ff;

    // Low-speed clock pin crosses into this domain through two flip-flops.
    nxt_state.ls_meta = low_speed_clock_i;
    nxt_state.ls_sync = state_ff.ls_meta;

    // Peripheral clock source: geared or undivided high-speed clock.
    if (periph_src) begin
      nxt_state.periph_tick = 1'b1;
    end else begin
      nxt_state.periph_tick = gear_tick;
    end

    // Data phase of a write: only writable fields change, reserved bits stay zero.
    if (state_ff.wr_pend && (state_ff.wr_addr == OFS_SYS_CLOCK_CONTROL)) begin
      nxt_state.sys_ctrl = hwdata_i & SYS_CLOCK_CONTROL_WMASK;
    end

    // Address phase. Reads use the next control value so that a read right
    // behind a write returns the new contents.
    nxt_state.wr_pend = 1'b0;
    nxt_state.ready = 1'b1;
    nxt_state.resp = HRESP_OKAY;
    if (addr_phase) begin
      nxt_state.wr_pend = hwrite_i && (hsize_i == HSIZE_WORD);
      nxt_state.wr_addr = addr_ofs;
      if (!hwrite_i) begin
        unique case (addr_ofs)
          OFS_SYS_CLOCK_CONTROL:   nxt_state.rdata = nxt_state.sys_ctrl;
          OFS_OSCILLATOR_CONTROL:  nxt_state.rdata = '0;
          OFS_STANDBY_CONTROL:     nxt_state.rdata = '0;
          OFS_PLL_SELECT:          nxt_state.rdata = '0;
          OFS_SYSTEM_CLOCK_SELECT: nxt_state.rdata = '0;
          default:                 nxt_state.rdata = '0;
        endcase
      end
    end

    // Half system clock: toggling on every geared tick gives fsys/2.
    if (gear_tick) begin
      nxt_state.half_tgl = ~state_ff.half_tgl;
    end

    unique case (out_sel)
      CGP_OUT_LOW_SPEED: begin
        nxt_state.pin = state_ff.ls_sync;
      end
      CGP_OUT_SYS_HALF: begin
        nxt_state.pin = state_ff.half_tgl;
      end
      CGP_OUT_SYS_FULL: begin
        if (sys_full_rate) begin
          nxt_state.pin = ~state_ff.pin;
        end else begin
          nxt_state.pin = gear_tick;
        end
      end
      CGP_OUT_PRESC_TAP: begin
        if (presc_full_rate) begin
          nxt_state.pin = ~state_ff.pin;
        end else begin
          nxt_state.pin = presc_tick;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff.sys_ctrl    <= SYS_CLOCK_CONTROL_RESET;
      state_ff.wr_pend     <= 1'b0;
      state_ff.wr_addr     <= '0;
      state_ff.rdata       <= '0;
      state_ff.ready       <= 1'b1;
      state_ff.resp        <= HRESP_OKAY;
      state_ff.ls_meta     <= 1'b0;
      state_ff.ls_sync     <= 1'b0;
      state_ff.periph_tick <= 1'b0;
      state_ff.half_tgl    <= 1'b0;
      state_ff.pin         <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign hreadyout_o        = state_ff.ready;
  assign hrdata_o           = state_ff.rdata;
  assign hresp_o            = state_ff.resp;
  assign gear_tick_o        = gear_tick;
  assign periph_tick_o      = state_ff.periph_tick;
  assign presc_tick_o       = presc_tick;
  assign clock_output_pin_o = state_ff.pin;

endmodule // cgp_top
`default_nettype wire

/* File: tb/cgp_checker.sv */
// Assertion checker for the clock gear and prescaler control block.
// Assumes word transfers only, with hready_i tied to hreadyout_o.
`timescale 1ns/10ps
`default_nettype none
module cgp_checker
  import cgp_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic [31:0] hrdata_o,
  input wire logic        hresp_o,
  input wire logic        low_speed_clock_i,
  input wire logic        gear_tick_o,
  input wire logic        periph_tick_o,
  input wire logic        presc_tick_o,
  input wire logic        clock_output_pin_o
);
  // A shadow of the control word; age counts steady cycles so dividers may settle first.
  logic [31:0] shd_ff;
  logic [3:0]  age_ff;
  logic        wr_ff;
  logic        rd_ff;
  logic        sys_ff;
  logic        take;
  logic        ok;
  assign take = hsel_i & htrans_i[1] & hready_i;
  assign ok = (age_ff == 4'hf);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shd_ff <= SYS_CLOCK_CONTROL_RESET;
      age_ff <= 4'h0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      sys_ff <= 1'b0;
    end else begin
      wr_ff <= take & hwrite_i & (hsize_i == HSIZE_WORD) & (haddr_i[7:0] == 8'h00);
      rd_ff <= take & ~hwrite_i;
      sys_ff <= (haddr_i[7:0] == 8'h00);
      if (wr_ff) shd_ff <= hwdata_i & SYS_CLOCK_CONTROL_WMASK;
      age_ff <= wr_ff ? 4'h0 : (ok ? age_ff : age_ff + 4'h1);
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_zero_wait: assert property (hreadyout_o) else $error("hready low");
  a_resp_okay: assert property (hresp_o == HRESP_OKAY) else $error("bad response");
  a_read_word: assert property (rd_ff |-> hrdata_o == (sys_ff ? shd_ff : 32'h0))
    else $error("read data wrong");
  a_gear_full: assert property (ok && shd_ff[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7}
    |-> gear_tick_o) else $error("undivided gear missed tick");
  a_gear_half: assert property (ok && shd_ff[2:0] == GEAR_DIV2
    |-> gear_tick_o != $past(gear_tick_o)) else $error("half gear not alternating");
  a_src_geared: assert property (ok && !shd_ff[12]
    |-> periph_tick_o == $past(gear_tick_o)) else $error("periph not gear");
  a_src_full: assert property (ok && shd_ff[12] |-> periph_tick_o)
    else $error("periph not undivided");
  a_presc_one: assert property (ok && shd_ff[10:8] == 3'h0
    |-> presc_tick_o == $past(periph_tick_o)) else $error("prescaler 1 wrong");
  a_out_half: assert property (ok && shd_ff[17:16] == 2'h1 && shd_ff[2:0] == 3'h0
    |-> clock_output_pin_o != $past(clock_output_pin_o)) else $error("half clock out wrong");
  c_write: cover property (wr_ff);
  c_read_other: cover property (rd_ff && !sys_ff);
  c_src_full: cover property (ok && shd_ff[12]);
endmodule // cgp_checker
bind cgp_top cgp_checker u_chk (.clk_sys_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hrdata_o, .hresp_o, .low_speed_clock_i,
  .gear_tick_o, .periph_tick_o, .presc_tick_o, .clock_output_pin_o);
`default_nettype wire

/* File: tb/cgp_top_tb.sv */
// Self-checking bench for the clock gear and prescaler control block.
// Drives the AHB-Lite port and low-speed pin itself; the checker is bound in.
`timescale 1ns/10ps
`default_nettype none
module cgp_top_tb;
  import cgp_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = HSIZE_WORD;
  logic [31:0] hwdata_i = 32'h0;
  logic        lsc = 1'b0;
  logic [31:0] rd;
  wire logic   rdy, resp, gt, pt, st, pin;
  wire logic [31:0] hrdata;
  int errors = 0;
  int samples_checked = 0;
  int n_g, n_p, n_s, n_r;
  always #5 clk_sys_i = ~clk_sys_i;
  cgp_top u_dut (.clk_sys_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(rdy), .hreadyout_o(rdy), .hrdata_o(hrdata), .hresp_o(resp),
    .low_speed_clock_i(lsc), .gear_tick_o(gt), .periph_tick_o(pt), .presc_tick_o(st),
    .clock_output_pin_o(pin));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge clk_sys_i);
      i++;
    end while (rdy !== 1'b1 && i < 50);
    if (rdy !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    wait_ready();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_ready();
    rd = hrdata;
  endtask
  // Settle, then count pulses and pin rises over 64 cycles, a multiple of every period.
  task automatic measure(input logic [31:0] w);
    logic last;
    bus(1'b1, 8'h00, w);
    repeat (16) @(posedge clk_sys_i);
    {n_g, n_p, n_s, n_r} = '0;
    last = pin;
    repeat (64) begin
      @(negedge clk_sys_i);
      n_g += int'(gt === 1'b1);
      n_p += int'(pt === 1'b1);
      n_s += int'(st === 1'b1);
      n_r += int'(pin === 1'b1 && last === 1'b0);
      last = pin;
    end
    @(posedge clk_sys_i);
  endtask
  task automatic t_regs();
    logic [7:0] ofs[5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
    bus(1'b0, 8'h00, 32'h0);
    check("reset word", rd, 32'h0001_0000);
    check("response", resp, 32'(HRESP_OKAY));
    // Every writable bit set, but gear and prescaler codes kept legal for software.
    bus(1'b1, 8'h00, 32'hffff_fdfe);
    bus(1'b0, 8'h00, 32'h0);
    check("writable bits", rd, 32'h0003_1506);
    foreach (ofs[k]) begin
      bus(1'b1, ofs[k], 32'hffff_ffff);
      bus(1'b0, ofs[k], 32'h0);
      check("other offset", rd, 32'h0);
    end
  endtask
  task automatic t_gear();
    logic [2:0] code[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h0};
    int exp[5] = '{64, 32, 16, 8, 64};
    foreach (code[k]) begin
      measure({29'h0, code[k]});
      check("gear ticks", n_g, exp[k]);
      check("prescaler 1 ticks", n_s, exp[k]);
    end
  endtask
  task automatic t_presc();
    for (int n = 0; n < 6; n++) begin
      measure({21'h0, 3'(n), 8'h00});
      check("prescaler ticks", n_s, (64 >> n));
    end
  endtask
  task automatic t_src();
    measure(32'h0000_1006);
    check("undivided periph", n_p, 64);
    measure(32'h0000_0006);
    check("geared periph", n_p, 8);
  endtask
  task automatic t_out();
    logic [31:0] w[3] = '{32'h0001_0000, 32'h0002_0004, 32'h0003_0200};
    int exp[3] = '{32, 32, 16};
    measure(32'h0);
    lsc <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    check("low speed high", pin, 1'b1);
    lsc <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    check("low speed low", pin, 1'b0);
    foreach (w[k]) begin
      measure(w[k]);
      check("clock out rises", n_r, exp[k]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_regs();
    t_gear();
    t_presc();
    t_src();
    t_out();
    finish_test();
  end
endmodule // cgp_top_tb
`default_nettype wire
